// ---- rtl/mcp_card.sv ----
// Memory card read parity checking, error latch and 8/16-bit lane steering,
// with an AXI4-Lite slave for the control and status port.
// Assumes bus cycle inputs are synchronous to core_clk and sampled each edge.
// What this block does
// - Read byte plus stored parity bit with odd ones count means no error.
// - Even ones count on a read lane raises that lane's parity fail.
// - Parity fail enters the error latch only while the check window is open.
// - A set error latch pulls the bus error line low.
// - Suppress control held low keeps the error latch cleared.
// - pDBIN means array read, onboard write means array write; buffers follow.
// - SIXTN status chooses word transfer versus single byte transfer.
// - Byte cycles use the even bank when A0 low, odd when high.
// - Byte writes take DO0-DO7 into the addressed even or odd bank.
// - Byte reads drive the selected bank byte onto DI0-DI7.
// - Word reads put the even bank byte on DATA0-DATA7.
// - Word writes route the lower lanes into the even bank.
// - Array is two even banks and two odd banks paired into words.
// - Card holds 256K bytes or 128K words.
// - Each write with parity storage enabled stores a parity bit making nine bits odd.
`timescale 1ns/10ps
`default_nettype none
module mcp_card #(
  parameter int BANK_AW = mcp_pkg::BANK_AW,
  parameter int PAIRS = mcp_pkg::PAIRS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bus memory cycle
  input wire mcp_pkg::mcp_cycle_t cyc,
  // Lower lanes DATA0-DATA7 driven on word reads
  output logic [7:0] data_lo_q,
  output logic data_lo_oe_q,
  // Upper lanes DI0-DI7 / DATA8-DATA15
  output logic [7:0] data_hi_q,
  output logic data_hi_oe_q,
  // Open-drain bus error line
  output logic error_out_q,
  output logic error_oe_q,
  // AXI4-Lite write address and data
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int DEPTH = PAIRS << BANK_AW;

  // Even and odd banks with one parity bit per byte
  logic [7:0] even_mem [DEPTH];
  logic [7:0] odd_mem [DEPTH];
  logic even_par [DEPTH];
  logic odd_par [DEPTH];

  logic [BANK_AW:0] widx;
  logic a0, word, rd, wr;
  assign widx = cyc.addr[BANK_AW+1:1];
  assign a0 = cyc.addr[0];
  assign word = ~cyc.sixtn_n;
  assign rd = cyc.pdbin & ~cyc.onboard_mem_write;
  assign wr = cyc.onboard_mem_write;

  // Control and status
  logic [31:0] ctrl_q, ctrl_d;
  logic suppress_n, store_en;
  assign suppress_n = ctrl_q[mcp_pkg::CTRL_SUPPRESS_BIT];
  assign store_en = ctrl_q[mcp_pkg::CTRL_STORE_BIT];

  // Array writes
  logic even_we, odd_we;
  logic [7:0] even_wd, odd_wd;
  always_comb begin
    even_we = wr & (word | ~a0);
    odd_we = wr & (word | a0);
    even_wd = cyc.wdata[7:0];
    odd_wd = word ? cyc.wdata[15:8] : cyc.wdata[7:0];
  end

  always_ff @(posedge core_clk) begin
    if (even_we) begin
      even_mem[widx] <= even_wd;
      // Parity left stale when storage is disabled, to force test errors
      if (store_en) begin
        even_par[widx] <= ~^even_wd;
      end
    end
    if (odd_we) begin
      odd_mem[widx] <= odd_wd;
      if (store_en) begin
        odd_par[widx] <= ~^odd_wd;
      end
    end
  end

  // Read path registers
  logic [7:0] rd_even_q, rd_odd_q, rd_even_d, rd_odd_d;
  logic [1:0] rd_par_q, rd_par_d, lane_q, lane_d;
  logic rd_q, rd_d;
  logic [7:0] lo_d, hi_d;
  logic lo_oe_d, hi_oe_d;
  always_comb begin
    rd_even_d = even_mem[widx];
    rd_odd_d = odd_mem[widx];
    rd_par_d = {odd_par[widx], even_par[widx]};
    rd_d = rd;
    lane_d = !rd ? 2'b00 : word ? 2'b11 : (a0 ? 2'b10 : 2'b01);
    lo_oe_d = rd & word;
    hi_oe_d = rd;
    lo_d = rd_even_d;
    hi_d = (word | a0) ? rd_odd_d : rd_even_d;
  end

  // Per-lane checkers
  logic fail_lo, fail_hi, fail_any;
  mcp_lane_check u_chk_lo (
    .data(rd_even_q),
    .par(rd_par_q[0]),
    .fail(fail_lo)
  );
  mcp_lane_check u_chk_hi (
    .data(rd_odd_q),
    .par(rd_par_q[1]),
    .fail(fail_hi)
  );
  assign fail_any = (fail_lo & lane_q[0]) | (fail_hi & lane_q[1]);

  // Error latch; suppress is a held clear and wins over a new failure
  logic err_q, err_d;
  logic [1:0] seen_q, seen_d;
  logic sample;
  assign sample = cyc.parity_check_window & rd_q;
  always_comb begin
    err_d = err_q | (sample & fail_any);
    if (!suppress_n) begin
      err_d = 1'b0;
    end
    seen_d = sample ? {fail_hi & lane_q[1], fail_lo & lane_q[0]} : seen_q;
  end

  // AXI4-Lite slave
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [3:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_d, rvalid_d, arready_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic aw_take, w_take, ar_take;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;

  always_comb begin
    aw_have_d = aw_have_q | aw_take;
    w_have_d = w_have_q | w_take;
    awaddr_d = aw_take ? s_axi_awaddr : awaddr_q;
    wdata_d = w_take ? s_axi_wdata : wdata_q;
    wstrb_d = w_take ? s_axi_wstrb : wstrb_q;
    ctrl_d = ctrl_q;
    bvalid_d = s_axi_bvalid & ~s_axi_bready;
    bresp_d = s_axi_bresp;
    if (aw_have_q && w_have_q && !s_axi_bvalid) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = mcp_pkg::RESP_OKAY;
      if (awaddr_q == mcp_pkg::CTRL_OFFS) begin
        for (int i = 0; i < 4; i++) begin
          if (wstrb_q[i]) begin
            ctrl_d[i*8 +: 8] = wdata_q[i*8 +: 8];
          end
        end
      end else if (awaddr_q != mcp_pkg::STATUS_OFFS) begin
        bresp_d = mcp_pkg::RESP_DECERR;
      end
    end
    rvalid_d = s_axi_rvalid & ~s_axi_rready;
    rdata_d = s_axi_rdata;
    rresp_d = s_axi_rresp;
    arready_d = ~rvalid_d & ~ar_take;
    if (ar_take) begin
      rvalid_d = 1'b1;
      rresp_d = mcp_pkg::RESP_OKAY;
      rdata_d = mcp_pkg::RDATA_ZERO;
      if (s_axi_araddr == mcp_pkg::CTRL_OFFS) begin
        rdata_d = ctrl_q;
      end else if (s_axi_araddr == mcp_pkg::STATUS_OFFS) begin
        rdata_d[mcp_pkg::STAT_ERR_BIT] = err_q;
        rdata_d[mcp_pkg::STAT_FAIL_LO_BIT] = seen_q[0];
        rdata_d[mcp_pkg::STAT_FAIL_HI_BIT] = seen_q[1];
      end else begin
        rresp_d = mcp_pkg::RESP_DECERR;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q <= mcp_pkg::CTRL_RESET;
      err_q <= 1'b0;
      seen_q <= 2'b00;
      rd_q <= 1'b0;
      lane_q <= 2'b00;
      rd_even_q <= 8'h00;
      rd_odd_q <= 8'h00;
      rd_par_q <= 2'b11;
      data_lo_q <= 8'h00;
      data_hi_q <= 8'h00;
      data_lo_oe_q <= 1'b0;
      data_hi_oe_q <= 1'b0;
      error_out_q <= 1'b0;
      error_oe_q <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      ctrl_q <= ctrl_d;
      err_q <= err_d;
      seen_q <= seen_d;
      rd_q <= rd_d;
      lane_q <= lane_d;
      rd_even_q <= rd_even_d;
      rd_odd_q <= rd_odd_d;
      rd_par_q <= rd_par_d;
      data_lo_q <= lo_d;
      data_hi_q <= hi_d;
      data_lo_oe_q <= lo_oe_d;
      data_hi_oe_q <= hi_oe_d;
      error_out_q <= 1'b0;
      error_oe_q <= err_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      s_axi_awready <= ~aw_have_d & ~aw_take;
      s_axi_wready <= ~w_have_d & ~w_take;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
    end
  end

  // Checks
  a_err_pin_low: assert property (@(posedge core_clk) disable iff (rst)
    error_oe_q == err_q && !error_out_q) else $error("error line not tracking latch");
  a_err_set_cause: assert property (@(posedge core_clk) disable iff (rst)
    $rose(err_q) |-> $past(sample) && $past(fail_any)) else $error("latch set without check");
  a_err_sets_on_fail: assert property (@(posedge core_clk) disable iff (rst)
    sample && fail_any && suppress_n |=> err_q) else $error("parity fail not latched");
  a_suppress_clears: assert property (@(posedge core_clk) disable iff (rst)
    !suppress_n |=> !err_q && !error_oe_q) else $error("suppress did not clear latch");
  a_err_holds: assert property (@(posedge core_clk) disable iff (rst)
    err_q && suppress_n |=> err_q) else $error("error latch dropped");
  a_good_no_fail: assert property (@(posedge core_clk) disable iff (rst)
    sample && !err_q && (^{rd_even_q, rd_par_q[0]} || !lane_q[0]) &&
    (^{rd_odd_q, rd_par_q[1]} || !lane_q[1]) |=> !err_q)
    else $error("odd count flagged");
  a_byte_lanes: assert property (@(posedge core_clk) disable iff (rst)
    rd && !word |=> data_hi_oe_q && !data_lo_oe_q && lane_q != 2'b11)
    else $error("byte read lane wrong");
  a_word_lanes: assert property (@(posedge core_clk) disable iff (rst)
    rd && word |=> data_hi_oe_q && data_lo_oe_q && lane_q == 2'b11)
    else $error("word read lanes wrong");
  a_no_drive_write: assert property (@(posedge core_clk) disable iff (rst)
    wr |=> !data_lo_oe_q && !data_hi_oe_q) else $error("drove bus during write");
  a_bresp_after_both: assert property (@(posedge core_clk) disable iff (rst)
    $rose(s_axi_bvalid) |-> $past(aw_have_q) && $past(w_have_q)) else $error("early bvalid");
endmodule
`default_nettype wire

// ---- rtl/mcp_pkg.sv ----
// Constants and carrier types for the memory card parity and lane steering block.
// Assumes a single core clock domain; bus pins arrive already synchronous.
package mcp_pkg;
  // Array geometry
  localparam int BANK_AW = 16;
  localparam int PAIRS = 2;
  localparam int BYTE_AW = BANK_AW + 2;
  // AXI4-Lite register map
  localparam logic [3:0] CTRL_OFFS = 4'h0;
  localparam logic [3:0] STATUS_OFFS = 4'h4;
  localparam int CTRL_STORE_BIT = 4;
  localparam int CTRL_SUPPRESS_BIT = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0030;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_FAIL_LO_BIT = 1;
  localparam int STAT_FAIL_HI_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // One memory cycle as seen at the card edge
  typedef struct packed {
    logic [BYTE_AW-1:0] addr;
    logic sixtn_n;
    logic pdbin;
    logic onboard_mem_write;
    logic parity_check_window;
    logic [15:0] wdata;
  } mcp_cycle_t;
endpackage

// ---- rtl/mcp_lane_check.sv ----
// One byte lane odd-parity checker.
// Assumes the byte and its stored parity bit are already registered.
`timescale 1ns/10ps
`default_nettype none
module mcp_lane_check (
  // Stored byte and its parity bit
  input wire logic [7:0] data,
  input wire logic par,
  // High when the nine bits hold an even count of ones
  output logic fail
);
  assign fail = ~^{data, par};
endmodule
`default_nettype wire

// ---- test/mcp_cpu_model.sv ----
// Bus master model issuing byte and word memory cycles to the card.
// Assumes the card samples cyc at every rising edge of core_clk.
`timescale 1ns/10ps
`default_nettype none
module mcp_cpu_model (
  // Clock
  input wire logic core_clk,
  // Memory cycle toward the card
  output var mcp_pkg::mcp_cycle_t cyc
);
  initial begin
    cyc = '0;
    cyc.sixtn_n = 1'b1;
  end
  // Card is fully populated, so word cycles are allowed
  task automatic wr(input logic [17:0] a, input logic [15:0] d, input logic w);
    @(posedge core_clk);
    cyc.addr <= a;
    cyc.sixtn_n <= !w;
    cyc.wdata <= d;
    cyc.onboard_mem_write <= 1'b1;
    @(posedge core_clk);
    cyc.onboard_mem_write <= 1'b0;
    cyc.sixtn_n <= 1'b1;
    // Released data lines show junk, never the last value
    cyc.wdata <= ~d;
  endtask
  task automatic rd(input logic [17:0] a, input logic w, input logic win);
    @(posedge core_clk);
    cyc.addr <= a;
    cyc.sixtn_n <= !w;
    cyc.pdbin <= 1'b1;
    @(posedge core_clk);
    cyc.parity_check_window <= win;
    @(posedge core_clk);
    cyc.pdbin <= 1'b0;
    cyc.parity_check_window <= 1'b0;
    cyc.sixtn_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- test/mcp_card_test.sv ----
// Self-checking bench for the card: lanes, parity latch, control port.
// Assumes the bus master model drives cyc; bench drives AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module mcp_card_test;
  logic core_clk, rst;
  mcp_pkg::mcp_cycle_t cyc;
  logic [7:0] dlo, dhi;
  logic dloe, dhoe, eout, eoe;
  logic [3:0] awa, ara, ws;
  logic [31:0] wd, rdat;
  logic awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
  logic [1:0] bresp, rresp;
  int error_cnt, cmp_count;

  mcp_cpu_model cpu (.core_clk(core_clk), .cyc(cyc));
  // Small banks keep the array cheap in simulation
  mcp_card #(.BANK_AW(4), .PAIRS(2)) dut (
    .core_clk(core_clk), .rst(rst), .cyc(cyc),
    .data_lo_q(dlo), .data_lo_oe_q(dloe), .data_hi_q(dhi), .data_hi_oe_q(dhoe),
    .error_out_q(eout), .error_oe_q(eoe),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));

  always #2.5 core_clk = ~core_clk;

  task end_sim;
    if (error_cnt == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task lost;
    error_cnt++;
    $display("mismatch at %0t: no answer", $time);
    end_sim;
  endtask
  task settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge core_clk);
    awa <= a;
    awv <= 1'b1;
    wd <= d;
    ws <= 4'hf;
    wv <= 1'b1;
    br <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bv) break;
    end
    br <= 1'b0;
    // A hang ends the run in the verdict task, so nothing may follow it
    if (n == 40) begin
      lost();
    end else begin
      chk(bresp, er);
    end
  endtask
  task axi_rd(input logic [3:0] a, input logic [31:0] ed, m, input logic [1:0] er);
    int n;
    @(posedge core_clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) break;
    end
    rr <= 1'b0;
    if (n == 40) begin
      lost();
    end else begin
      chk(rdat & m, ed);
      chk(rresp, er);
    end
  endtask

  task t_reset;
    #1;
    chk({eoe, dhoe, dloe}, 0);
    axi_rd(mcp_pkg::CTRL_OFFS, mcp_pkg::CTRL_RESET, '1, mcp_pkg::RESP_OKAY);
  endtask
  task t_lanes;
    cpu.wr(18'h0_0003, 16'h003c, 0);
    // Junk upper byte must not leak into the odd bank
    cpu.wr(18'h0_0002, 16'hffa5, 0);
    cpu.wr(18'h2_0004, 16'h5ac3, 1);
    cpu.rd(18'h0_0002, 0, 1);
    #1;
    chk({dhoe, dhi, dloe}, 10'h34a);
    cpu.rd(18'h0_0003, 0, 1);
    #1;
    chk(dhi, 8'h3c);
    cpu.rd(18'h2_0004, 1, 1);
    #1;
    chk({dloe, dlo}, 9'h1c3);
    chk({dhoe, dhi}, 9'h15a);
    cpu.rd(18'h0_0002, 1, 1);
    #1;
    chk({dhi, dlo}, 16'h3ca5);
    cpu.rd(18'h2_0005, 0, 0);
    #1;
    chk(dhi, 8'h5a);
    settle();
    chk({dhoe, dloe}, 0);
    chk(eoe, 0);
  endtask
  task t_parity;
    cpu.wr(18'h0_0006, 16'h0000, 0);
    cpu.wr(18'h0_0007, 16'h0007, 0);
    axi_wr(mcp_pkg::CTRL_OFFS, 32'h0000_0020, mcp_pkg::RESP_OKAY);
    cpu.wr(18'h0_0006, 16'h0001, 0);
    cpu.rd(18'h0_0006, 0, 0);
    settle();
    chk(eoe, 0);
    cpu.rd(18'h0_0007, 0, 1);
    settle();
    chk(eoe, 0);
    cpu.rd(18'h0_0006, 0, 1);
    settle();
    chk({eoe, eout}, 2'b10);
    axi_rd(mcp_pkg::STATUS_OFFS, 32'h0000_0003, 32'h0000_0007, mcp_pkg::RESP_OKAY);
    repeat (20) @(posedge core_clk);
    #1;
    chk(eoe, 1);
    axi_wr(mcp_pkg::CTRL_OFFS, 32'h0000_0010, mcp_pkg::RESP_OKAY);
    settle();
    chk(eoe, 0);
    cpu.rd(18'h0_0006, 1, 1);
    settle();
    chk(eoe, 0);
    axi_wr(mcp_pkg::CTRL_OFFS, 32'h0000_0030, mcp_pkg::RESP_OKAY);
    settle();
    chk(eoe, 0);
    // Stale odd parity makes the upper lane fail on its own
    axi_wr(mcp_pkg::CTRL_OFFS, 32'h0000_0020, mcp_pkg::RESP_OKAY);
    cpu.wr(18'h0_0007, 16'h0006, 0);
    cpu.rd(18'h0_0007, 0, 1);
    settle();
    chk(eoe, 1);
    axi_rd(mcp_pkg::STATUS_OFFS, 32'h0000_0005, 32'h0000_0007, mcp_pkg::RESP_OKAY);
    axi_wr(mcp_pkg::CTRL_OFFS, 32'h0000_0010, mcp_pkg::RESP_OKAY);
    axi_wr(mcp_pkg::CTRL_OFFS, 32'h0000_0030, mcp_pkg::RESP_OKAY);
    settle();
    chk(eoe, 0);
  endtask
  task t_axi;
    axi_rd(4'h8, mcp_pkg::RDATA_ZERO, '1, mcp_pkg::RESP_DECERR);
    axi_wr(mcp_pkg::STATUS_OFFS, 32'hffff_ffff, mcp_pkg::RESP_OKAY);
    axi_wr(4'h8, 32'h0000_0001, mcp_pkg::RESP_DECERR);
    axi_rd(mcp_pkg::STATUS_OFFS, 32'h0000_0004, 32'h0000_0007, mcp_pkg::RESP_OKAY);
    axi_rd(mcp_pkg::CTRL_OFFS, 32'h0000_0030, '1, mcp_pkg::RESP_OKAY);
  endtask

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    {awa, ara, ws, wd} = '0;
    {awv, wv, br, arv, rr} = '0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_lanes();
    t_parity();
    t_axi();
    end_sim();
  end
endmodule
`default_nettype wire
